//--- core/blmc_pkg.sv
/*
   Package for the byte link mode controller: mode encoding, the carrier structs
   for low-power requests and mode status, and reset values.
   Assumes one clock domain and a synchronous active-high reset.
*/
package blmc_pkg;

   // ==========================================================================
   // Mode encoding.
   typedef enum logic [2:0] {
      BLMC_OFF   = 3'h0,
      BLMC_RESET = 3'h1,
      BLMC_RUN   = 3'h2,
      BLMC_WAIT  = 3'h3,
      BLMC_STOP  = 3'h4
   } blmc_mode_e;

   // ==========================================================================
   // Low-power request from the processor, same clock domain.
   typedef struct packed {
      logic wait_instr;
      logic stop_instr;
   } blmc_lp_req_s;

   // ==========================================================================
   // Mode status carried to the rest of the link controller.
   typedef struct packed {
      logic in_reset;
      logic link_enable;
      logic drive_enable;
      logic clock_run;
   } blmc_stat_s;

   localparam logic [2:0] BLMC_MODE_RST_VAL = 3'h1;
   localparam logic BLMC_WAKE_IRQ_RST_VAL = 1'b0;
   localparam logic [7:0] BLMC_VEC_WAKEUP = 8'h20;
   localparam logic [7:0] BLMC_VEC_NONE = 8'h00;
   localparam logic BLMC_SELECT_RST_VAL = 1'b0;

endpackage

//--- core/blmc_mode_ctrl.sv
/*
   Operating-mode controller of the byte link controller: sequences reset, run,
   wait and stop, and raises the stop wakeup interrupt.
   Assumes the processor resets and low-power requests come from logic on CLK,
   and that the bus receive line and power-good arrive from pins.
*/
// Behaviour
// - Five modes: off, reset, run, wait, stop.
// - Any reset source forces reset mode immediately; from off, only RST does; without power-good, other resets move reset to off.
// - Registers held at reset values in reset.
// - Outputs held, inputs ignored during reset.
// - System clock keeps running during reset.
// - Run entered once all resets released.
// - Bus activity returns wait to run.
// - Bus activity returns stop to run.
// - Network traffic only in run mode.
// - Select clear plus wait enters wait.
// - Select set plus wait/stop enters stop.
// - Stop wakeup raises top-priority unmaskable interrupt.
// - Low-power modes keep register contents unchanged.
module blmc_mode_ctrl
   import blmc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic POWER_GOOD,
   input wire logic LOW_VOLTAGE_RESET,
   input wire logic EXT_RESET,
   input wire logic STOP_IN_WAIT_SELECT_WR,
   input wire logic STOP_IN_WAIT_SELECT_IN,
   input wire blmc_pkg::blmc_lp_req_s LP_REQ,
   input wire logic LINK_RX,
   input wire logic WAKE_ACK,
   output logic [2:0] MODE,
   output blmc_pkg::blmc_stat_s STATUS,
   output logic STOP_IN_WAIT_SELECT,
   output logic WAKE_IRQ,
   output logic [7:0] LINK_STATE_VECTOR
);
   import blmc_pkg::*;

   // ==========================================================================
   // Pin synchronisers.
   logic [1:0] rx_sync_reg;
   logic [1:0] pg_sync_reg;
   logic rx_prev_reg;
   logic any_reset;
   logic activity;
   blmc_mode_e mode_reg;
   blmc_mode_e mode_next;

   always_ff @(posedge CLK) begin
      if (CE) begin
         rx_sync_reg <= {rx_sync_reg[0], LINK_RX};
         pg_sync_reg <= {pg_sync_reg[0], POWER_GOOD};
      end
   end

   // Passive-to-active edge; the history is cleared to passive in reset, so a level still active at release reads as an edge.
   always_ff @(posedge CLK) begin
      if (RST || any_reset) begin
         rx_prev_reg <= 1'b0;
      end else if (CE) begin
         rx_prev_reg <= rx_sync_reg[1];
      end
   end

   assign any_reset = RST || LOW_VOLTAGE_RESET || EXT_RESET;
   assign activity = rx_sync_reg[1] && !rx_prev_reg;

   // ==========================================================================
   // Mode sequencing.
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         BLMC_OFF: begin
            if (pg_sync_reg[1]) begin
               mode_next = BLMC_RESET;
            end
         end
         BLMC_RESET: begin
            mode_next = BLMC_RUN;
         end
         BLMC_RUN: begin
            if (LP_REQ.wait_instr && !STOP_IN_WAIT_SELECT) begin
               mode_next = BLMC_WAIT;
            end else if ((LP_REQ.wait_instr || LP_REQ.stop_instr) && STOP_IN_WAIT_SELECT) begin
               mode_next = BLMC_STOP;
            end
         end
         BLMC_WAIT: begin
            if (activity) begin
               mode_next = BLMC_RUN;
            end
         end
         BLMC_STOP: begin
            if (activity) begin
               mode_next = BLMC_RUN;
            end
         end
         default: mode_next = BLMC_RESET;
      endcase
   end

   // Reset overrides every mode but off, which among resets only RST overrides; with power-good lost, a reset other than RST moves reset mode to off.
   // The clock is never gated here, so reset logic keeps running.
   always_ff @(posedge CLK) begin
      if (any_reset) begin
         if (mode_reg == BLMC_RESET && !pg_sync_reg[1] && !RST) begin
            mode_reg <= BLMC_OFF;
         end else if (mode_reg != BLMC_OFF || RST) begin
            mode_reg <= BLMC_RESET;
         end
      end else if (CE) begin
         mode_reg <= mode_next;
      end
   end

   // ==========================================================================
   // Control bit, written only in run mode and cleared by reset, so low-power modes keep it.
   always_ff @(posedge CLK) begin
      if (any_reset) begin
         STOP_IN_WAIT_SELECT <= BLMC_SELECT_RST_VAL;
      end else if (CE && STOP_IN_WAIT_SELECT_WR && mode_reg == BLMC_RUN) begin
         STOP_IN_WAIT_SELECT <= STOP_IN_WAIT_SELECT_IN;
      end
   end

   // ==========================================================================
   // Stop wakeup interrupt; a new wakeup in the acknowledge cycle wins.
   always_ff @(posedge CLK) begin
      if (any_reset) begin
         WAKE_IRQ <= BLMC_WAKE_IRQ_RST_VAL;
         LINK_STATE_VECTOR <= BLMC_VEC_NONE;
      end else if (CE) begin
         if (mode_reg == BLMC_STOP && activity) begin
            WAKE_IRQ <= 1'b1;
            LINK_STATE_VECTOR <= BLMC_VEC_WAKEUP;
         end else if (WAKE_ACK) begin
            WAKE_IRQ <= 1'b0;
            LINK_STATE_VECTOR <= BLMC_VEC_NONE;
         end
      end
   end

   // ==========================================================================
   // Registered outputs.
   always_ff @(posedge CLK) begin
      if (any_reset) begin
         MODE <= BLMC_MODE_RST_VAL;
         STATUS <= '{in_reset: 1'b1, link_enable: 1'b0, drive_enable: 1'b0, clock_run: 1'b1};
      end else if (CE) begin
         MODE <= mode_next;
         STATUS.in_reset <= (mode_next == BLMC_RESET);
         STATUS.link_enable <= (mode_next == BLMC_RUN);
         STATUS.drive_enable <= (mode_next == BLMC_RUN);
         STATUS.clock_run <= (mode_next != BLMC_STOP && mode_next != BLMC_OFF);
      end
   end

   // ==========================================================================
   // Checks.
   property p_reset_forces;
      @(posedge CLK) (LOW_VOLTAGE_RESET || EXT_RESET) && mode_reg != BLMC_OFF
         |=> mode_reg inside {BLMC_RESET, BLMC_OFF};
   endproperty
   a_reset_forces: assert property (p_reset_forces) else $error("reset not taken");

   property p_reg_held;
      @(posedge CLK) any_reset |=> !WAKE_IRQ && !STOP_IN_WAIT_SELECT
         && LINK_STATE_VECTOR == BLMC_VEC_NONE;
   endproperty
   a_reg_held: assert property (p_reg_held) else $error("register not reset");

   property p_out_held;
      @(posedge CLK) any_reset |=> STATUS.in_reset && !STATUS.link_enable;
   endproperty
   a_out_held: assert property (p_out_held) else $error("outputs not held");

   property p_run_after;
      @(posedge CLK) disable iff (RST) mode_reg == BLMC_RESET && !any_reset && CE
         |=> mode_reg == BLMC_RUN;
   endproperty
   a_run_after: assert property (p_run_after) else $error("run not entered");

   property p_wait_wake;
      @(posedge CLK) disable iff (any_reset) mode_reg == BLMC_WAIT && activity && CE
         |=> mode_reg == BLMC_RUN;
   endproperty
   a_wait_wake: assert property (p_wait_wake) else $error("wait wake missed");

   property p_stop_wake;
      @(posedge CLK) disable iff (any_reset) mode_reg == BLMC_STOP && activity && CE
         |=> mode_reg == BLMC_RUN && WAKE_IRQ && LINK_STATE_VECTOR == BLMC_VEC_WAKEUP;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop wake missed");

   property p_link_run;
      @(posedge CLK) disable iff (RST) STATUS.link_enable
         |-> MODE == BLMC_RUN && mode_reg == BLMC_RUN;
   endproperty
   a_link_run: assert property (p_link_run) else $error("link outside run");

   property p_enter_wait;
      @(posedge CLK) disable iff (any_reset)
         mode_reg == BLMC_RUN && CE && LP_REQ.wait_instr && !STOP_IN_WAIT_SELECT
         |=> mode_reg == BLMC_WAIT && !STATUS.drive_enable && !STATUS.link_enable;
   endproperty
   a_enter_wait: assert property (p_enter_wait) else $error("wait not entered");

   property p_enter_stop;
      @(posedge CLK) disable iff (any_reset) mode_reg == BLMC_RUN && CE && STOP_IN_WAIT_SELECT
         && (LP_REQ.wait_instr || LP_REQ.stop_instr)
         |=> mode_reg == BLMC_STOP && !STATUS.clock_run;
   endproperty
   a_enter_stop: assert property (p_enter_stop) else $error("stop not entered");

   property p_sel_kept;
      @(posedge CLK) disable iff (any_reset) mode_reg != BLMC_RUN
         |=> $stable(STOP_IN_WAIT_SELECT);
   endproperty
   a_sel_kept: assert property (p_sel_kept) else $error("select changed");

   c_wait_cycle: cover property (@(posedge CLK) mode_reg == BLMC_WAIT ##[1:50] mode_reg == BLMC_RUN);
   c_stop_cycle: cover property (@(posedge CLK) mode_reg == BLMC_STOP ##[1:50] WAKE_IRQ);
   c_power_off: cover property (@(posedge CLK) mode_reg == BLMC_OFF);

endmodule

//--- tb/blmc_bus_model.sv
/*
   Far-side network model: drives passive-to-active edges onto the receive pin.
   Assumes the bench calls activity() and that the idle bus reads passive (0).
*/
module blmc_bus_model (
   input wire logic CLK,
   output logic LINK_RX
);
   timeunit 1ns;
   timeprecision 1ns;
   // =========================================================================
   // Activity bursts; the bus rests passive between them.
   initial LINK_RX = 1'b0;
   task automatic activity(input int cycles);
      @(negedge CLK) LINK_RX = 1'b1;
      repeat (cycles) @(negedge CLK);
      LINK_RX = 1'b0;
   endtask
endmodule

//--- tb/tb.sv
/*
   Self-checking bench for the mode controller, one task per scenario.
   Assumes the bus model drives the receive pin; clock enable held on.
*/
`define CHK(A, E) begin samples_checked++; if ((A) !== (E)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (A), (E)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import blmc_pkg::*;
   // =========================================================================
   // Signals and instances
   logic clk = 1'b0, rst = 1'b1, low_volt = 1'b0, ext = 1'b0, swr = 1'b0, sin = 1'b0;
   logic ack = 1'b0, pg = 1'b1, rx, sel, irq;
   blmc_lp_req_s lp_req = '0;
   blmc_stat_s stat;
   logic [2:0] mode;
   logic [7:0] vec;
   int err_count = 0, samples_checked = 0, cycles = 0;
   always #5 clk = ~clk;
   blmc_bus_model bus (.CLK(clk), .LINK_RX(rx));
   blmc_mode_ctrl dut (.CLK(clk), .RST(rst), .CE(1'b1), .POWER_GOOD(pg),
      .LOW_VOLTAGE_RESET(low_volt), .EXT_RESET(ext), .STOP_IN_WAIT_SELECT_WR(swr),
      .STOP_IN_WAIT_SELECT_IN(sin), .LP_REQ(lp_req), .LINK_RX(rx), .WAKE_ACK(ack),
      .MODE(mode), .STATUS(stat), .STOP_IN_WAIT_SELECT(sel), .WAKE_IRQ(irq),
      .LINK_STATE_VECTOR(vec));
   // =========================================================================
   // Shared drivers; each request pulse lasts one cycle, the wake burst two, and each is judged after it lands.
   task automatic lp(input logic w, input logic s);
      @(negedge clk) lp_req = '{wait_instr: w, stop_instr: s};
      @(negedge clk) lp_req = '0;
   endtask
   task automatic wake();
      int i;
      bus.activity(2);
      for (i = 0; i < 8 && mode !== BLMC_RUN; i++) @(negedge clk);
   endtask
   // =========================================================================
   // Scenarios
   task automatic t_reset();
      lp(1'b1, 1'b0);
      bus.activity(1);
      `CHK(mode, BLMC_RESET)
      `CHK(stat, 4'h9)
      `CHK({irq, vec, sel}, 10'h000)
      @(negedge clk) rst = 1'b0;
      `CHK(mode, BLMC_RESET)
      @(negedge clk);
      `CHK(mode, BLMC_RUN)
      $display("reset test done");
   endtask
   task automatic t_wait();
      lp(1'b0, 1'b1);
      `CHK(mode, BLMC_RUN)
      lp(1'b1, 1'b0);
      `CHK(mode, BLMC_WAIT)
      `CHK({stat.link_enable, stat.drive_enable, stat.clock_run}, 3'h1)
      lp(1'b0, 1'b1);
      `CHK(mode, BLMC_WAIT)
      @(negedge clk) {swr, sin} = 2'h3;
      @(negedge clk) {swr, sin} = 2'h0;
      `CHK(sel, 1'b0)
      wake();
      `CHK(mode, BLMC_RUN)
      `CHK({stat.link_enable, stat.drive_enable, irq}, 3'h6)
      $display("wait test done");
   endtask
   task automatic t_stop(input logic w);
      @(negedge clk) {swr, sin} = 2'h3;
      @(negedge clk) {swr, sin} = 2'h0;
      lp(w, ~w);
      `CHK(mode, BLMC_STOP)
      `CHK(stat.clock_run, 1'b0)
      wake();
      `CHK(mode, BLMC_RUN)
      `CHK({irq, vec}, 9'h120)
      `CHK(sel, 1'b1)
      @(negedge clk) ack = 1'b1;
      @(negedge clk) ack = 1'b0;
      `CHK({irq, vec}, 9'h000)
      @(negedge clk) {swr, sin} = 2'h2;
      @(negedge clk) {swr, sin} = 2'h0;
      `CHK(sel, 1'b0)
      $display("stop test done");
   endtask
   task automatic t_src(input logic which);
      lp(1'b1, 1'b0);
      @(negedge clk) {low_volt, ext} = which ? 2'h1 : 2'h2;
      @(negedge clk) {low_volt, ext} = 2'h0;
      `CHK(mode, BLMC_RESET)
      `CHK({sel, irq}, 2'h0)
      @(negedge clk);
      `CHK(mode, BLMC_RUN)
      $display("reset source test done");
   endtask
   task automatic t_off();
      int i;
      @(negedge clk) low_volt = 1'b1;
      @(negedge clk) pg = 1'b0;
      repeat (4) @(negedge clk);
      low_volt = 1'b0;
      @(negedge clk);
      `CHK(mode, BLMC_OFF)
      `CHK(stat, 4'h0)
      pg = 1'b1;
      for (i = 0; i < 8 && mode !== BLMC_RUN; i++) @(negedge clk);
      `CHK(mode, BLMC_RUN)
      $display("power off test done");
   endtask
   // =========================================================================
   // Closing, timeout and main sequence
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      t_reset();
      t_wait();
      t_stop(1'b0);
      t_stop(1'b1);
      t_src(1'b0);
      t_stop(1'b1);
      t_src(1'b1);
      t_off();
      finish_test();
   end
endmodule
